// ===== e1ct_terminal.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`include "e1ct_map.svh"

// Overview of operation
// - Power-down pin floats that channel's line outputs
// - Board test pin low floats the receive pins and both channels' line outputs
// - Loss output high while signal lost
// - Dual-rail: positive and negative rails output separately
// - Single-rail: decoded data out as NRZ
// - Single-rail: violation pulses one recovered clock
// - Single-rail AMI coding: every bipolar violation flagged
// - All-ones input sends AMI ones on master clock
module e1ct_terminal
  import e1ct_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Shared pins
  input wire logic master_clock,
  input wire logic board_test_float_n,
  output logic rxPinOe,
  // Channel 2 terminal side
  input wire logic tx_clock_ch2,
  input wire logic tx_posrail_or_nrz_ch2,
  input wire logic tx_negrail_or_coding_sel_ch2,
  input wire logic tx_all_ones_ch2,
  input wire logic tx_powerdown_ch2,
  output logic recovered_clock_ch2,
  output logic rx_posrail_or_nrz_ch2,
  output logic rx_negrail_or_violation_ch2,
  output logic signal_loss_ch2,
  // Channel 2 line side
  input wire logic rx_line_tip_ch2,
  input wire logic rx_line_ring_ch2,
  output logic tx_line_tip_ch2,
  output logic tx_line_ring_ch2,
  output logic tx_line_oe_ch2,
  // Channel 4 terminal side
  input wire logic tx_clock_ch4,
  input wire logic tx_posrail_or_nrz_ch4,
  input wire logic tx_negrail_or_coding_sel_ch4,
  input wire logic tx_all_ones_ch4,
  input wire logic tx_powerdown_ch4,
  output logic recovered_clock_ch4,
  output logic rx_posrail_or_nrz_ch4,
  output logic rx_negrail_or_violation_ch4,
  output logic signal_loss_ch4,
  // Channel 4 line side
  input wire logic rx_line_tip_ch4,
  input wire logic rx_line_ring_ch4,
  output logic tx_line_tip_ch4,
  output logic tx_line_ring_ch4,
  output logic tx_line_oe_ch4
);

  e1ct_top_type s;
  e1ct_top_type next_s;
  logic mclkRise;
  logic floatN;

  // Synchronisers, register file and bus slave
  always_comb begin
    next_s = s;
    next_s.mclkSync = {s.mclkSync[0], master_clock};
    next_s.mclkPrev = s.mclkSync[1];
    next_s.floatSync = {s.floatSync[0], board_test_float_n};
    // Address and data are caught independently, in either order
    if (awvalid && !s.awHeld) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = {awaddr[3:2], 2'b00};
    end
    if (wvalid && !s.wHeld) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    // Holding the response blocks a second write until bready
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `E1CT_OKAY;
      case (s.awAddr)
        `E1CT_CTRL_OFS: begin
          if (s.wStrb[0]) begin
            next_s.ctrl = s.wData[1:0];
          end
        end
        `E1CT_LOSTHR_OFS: begin
          if (s.wStrb[0]) begin
            next_s.losThr[7:0] = s.wData[7:0];
          end
          if (s.wStrb[1]) begin
            next_s.losThr[11:8] = s.wData[11:8];
          end
        end
        `E1CT_STATUS_OFS: begin
          next_s.bresp = `E1CT_OKAY; // Read-only, write ignored
        end
        default: begin
          next_s.bresp = `E1CT_SLVERR;
        end
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // Reads answer on the next edge
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `E1CT_OKAY;
      next_s.rdata = 32'h0000_0000;
      case ({araddr[3:2], 2'b00})
        `E1CT_CTRL_OFS: begin
          next_s.rdata[1:0] = s.ctrl;
        end
        `E1CT_LOSTHR_OFS: begin
          next_s.rdata[11:0] = s.losThr;
        end
        `E1CT_STATUS_OFS: begin
          next_s.rdata[1:0] = {signal_loss_ch4, signal_loss_ch2};
        end
        default: begin
          next_s.rresp = `E1CT_SLVERR;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
      s.ctrl <= `E1CT_CTRL_RST;
      s.losThr <= `E1CT_LOSTHR_RST;
    end else begin
      s <= next_s;
    end
  end

  // Handshake and pin-enable outputs
  assign mclkRise = s.mclkSync[1] && !s.mclkPrev;
  assign floatN = s.floatSync[1];
  assign rxPinOe = floatN;
  assign awready = !s.awHeld;
  assign wready = !s.wHeld;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;

  // Channel 2
  e1ct_channel u_ch2 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .mclkRise(mclkRise),
    .floatN(floatN),
    .singleRail(s.ctrl[0]),
    .losThr(s.losThr),
    .txClk(tx_clock_ch2),
    .txPosNrz(tx_posrail_or_nrz_ch2),
    .txNegCode(tx_negrail_or_coding_sel_ch2),
    .txAllOnes(tx_all_ones_ch2),
    .txPowerdown(tx_powerdown_ch2),
    .rxTip(rx_line_tip_ch2),
    .rxRing(rx_line_ring_ch2),
    .txLineTip(tx_line_tip_ch2),
    .txLineRing(tx_line_ring_ch2),
    .txLineOe(tx_line_oe_ch2),
    .recClk(recovered_clock_ch2),
    .rxPosNrz(rx_posrail_or_nrz_ch2),
    .rxNegViol(rx_negrail_or_violation_ch2),
    .signalLoss(signal_loss_ch2)
  );

  // Channel 4
  e1ct_channel u_ch4 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .mclkRise(mclkRise),
    .floatN(floatN),
    .singleRail(s.ctrl[1]),
    .losThr(s.losThr),
    .txClk(tx_clock_ch4),
    .txPosNrz(tx_posrail_or_nrz_ch4),
    .txNegCode(tx_negrail_or_coding_sel_ch4),
    .txAllOnes(tx_all_ones_ch4),
    .txPowerdown(tx_powerdown_ch4),
    .rxTip(rx_line_tip_ch4),
    .rxRing(rx_line_ring_ch4),
    .txLineTip(tx_line_tip_ch4),
    .txLineRing(tx_line_ring_ch4),
    .txLineOe(tx_line_oe_ch4),
    .recClk(recovered_clock_ch4),
    .rxPosNrz(rx_posrail_or_nrz_ch4),
    .rxNegViol(rx_negrail_or_violation_ch4),
    .signalLoss(signal_loss_ch4)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_floatHeld;
    !board_test_float_n [*3];
  endsequence
  property p_float;
    s_floatHeld |-> !rxPinOe && !tx_line_oe_ch2 && !tx_line_oe_ch4;
  endproperty
  a_float: assert property (p_float) else $error("Outputs driven in board test");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("Write response dropped");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("Read data dropped");
  property p_ctrlWr;
    $rose(bvalid) && $past(s.awAddr) == `E1CT_CTRL_OFS && $past(s.wStrb[0])
      |-> s.ctrl == $past(s.wData[1:0]);
  endproperty
  a_ctrlWr: assert property (p_ctrlWr) else $error("Control write lost");

endmodule : e1ct_terminal

// ===== e1ct_map.svh
`ifndef E1CT_MAP_SVH
`define E1CT_MAP_SVH
// Register byte offsets
`define E1CT_CTRL_OFS 4'h0
`define E1CT_LOSTHR_OFS 4'h4
`define E1CT_STATUS_OFS 4'h8
// Register reset values
`define E1CT_CTRL_RST 2'h0
`define E1CT_LOSTHR_RST 12'h020
// Bus response codes
`define E1CT_OKAY 2'h0
`define E1CT_SLVERR 2'h2
// Pin positions inside the channel synchroniser vector
`define E1CT_TCK 0
`define E1CT_TP 1
`define E1CT_TN 2
`define E1CT_RTP 3
`define E1CT_RRG 4
`define E1CT_PD 5
`define E1CT_AOS 6
// Timing: reference period and E1 bit period in ns
`define E1CT_REF_NS 5
`define E1CT_BIT_NS 488
`define E1CT_BIT_CYC (`E1CT_BIT_NS / `E1CT_REF_NS)
`define E1CT_HALF_CYC (`E1CT_BIT_CYC / 2)
`endif

// ===== e1ct_pkg.sv
package e1ct_pkg;

  // Whole state of one line channel
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic txClkPrev;
    logic tip;
    logic ring;
    logic txPol;
    logic [6:0] phase;
    logic rclk;
    logic [1:0] rxPrev;
    logic posSeen;
    logic negSeen;
    logic rxPol;
    logic [1:0] zeroRun;
    logic [3:0] shiftData;
    logic [11:0] losCnt;
    logic los;
    logic rxPos;
    logic rxNeg;
  } e1ct_ch_type;

  // Whole state of the top: synchronisers, registers, bus slave
  typedef struct packed {
    logic [1:0] mclkSync;
    logic mclkPrev;
    logic [1:0] floatSync;
    logic [1:0] ctrl;
    logic [11:0] losThr;
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } e1ct_top_type;

endpackage : e1ct_pkg

// ===== e1ct_channel.sv
`include "e1ct_map.svh"

module e1ct_channel
  import e1ct_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Shared control, plus this channel's own rail mode
  input wire logic mclkRise,
  input wire logic floatN,
  input wire logic singleRail,
  input wire logic [11:0] losThr,
  // Terminal-side and line-receiver pins
  input wire logic txClk,
  input wire logic txPosNrz,
  input wire logic txNegCode,
  input wire logic txAllOnes,
  input wire logic txPowerdown,
  input wire logic rxTip,
  input wire logic rxRing,
  // Line driver
  output logic txLineTip,
  output logic txLineRing,
  output logic txLineOe,
  // Receive outputs
  output logic recClk,
  output logic rxPosNrz,
  output logic rxNegViol,
  output logic signalLoss
);

  e1ct_ch_type s;
  e1ct_ch_type next_s;
  logic [1:0] railEdge;
  logic pulseEdge;
  logic wrap;
  logic pulse;
  logic amiSel;
  logic bpv;
  logic sub;

  // Next state of transmitter, clock recovery, decoder and loss detector
  always_comb begin
    next_s = s;
    // Only a rising rail edge counts as a mark: the tail of a half-width mark
    // is still high at the decision and must not leak into the next bit
    railEdge = s.sync2[`E1CT_RRG:`E1CT_RTP] & ~s.rxPrev;
    pulseEdge = |railEdge;
    wrap = (s.phase == 7'(`E1CT_BIT_CYC - 1));
    pulse = s.posSeen | s.negSeen;
    amiSel = s.sync2[`E1CT_TN]; // Coding pin high selects AMI in single-rail
    bpv = pulse && (s.posSeen == s.rxPol);
    sub = !amiSel && bpv && (s.zeroRun >= 2'h2);
    next_s.sync1 = {txAllOnes, txPowerdown, rxRing, rxTip, txNegCode, txPosNrz, txClk};
    next_s.sync2 = s.sync1;
    next_s.txClkPrev = s.sync2[`E1CT_TCK];
    if (s.sync2[`E1CT_PD]) begin
      next_s.tip = 1'b0;
      next_s.ring = 1'b0;
    end else if (s.sync2[`E1CT_AOS]) begin
      if (mclkRise) begin
        next_s.tip = !s.txPol;
        next_s.ring = s.txPol;
        next_s.txPol = !s.txPol;
      end
    end else if (s.sync2[`E1CT_TCK] && !s.txClkPrev) begin
      if (singleRail) begin
        next_s.tip = s.sync2[`E1CT_TP] & !s.txPol;
        next_s.ring = s.sync2[`E1CT_TP] & s.txPol;
        next_s.txPol = s.txPol ^ s.sync2[`E1CT_TP];
      end else begin
        next_s.tip = s.sync2[`E1CT_TP];
        next_s.ring = s.sync2[`E1CT_TN];
      end
    end
    // Phase re-centres on each pulse edge; a wrap always wins so rclk rises
    next_s.rxPrev = s.sync2[`E1CT_RRG:`E1CT_RTP];
    next_s.posSeen = s.posSeen | railEdge[0];
    next_s.negSeen = s.negSeen | railEdge[1];
    if (wrap) begin
      next_s.phase = 7'h00;
    end else if (pulseEdge) begin
      next_s.phase = 7'(`E1CT_HALF_CYC);
    end else begin
      next_s.phase = s.phase + 7'h01;
    end
    next_s.rclk = (next_s.phase < 7'(`E1CT_HALF_CYC));
    // Bit decision once per recovered clock, outputs move with rclk
    if (wrap) begin
      next_s.posSeen = railEdge[0];
      next_s.negSeen = railEdge[1];
      if (pulse) begin
        next_s.rxPol = s.posSeen;
      end
      next_s.zeroRun = pulse ? 2'h0 : ((s.zeroRun == 2'h3) ? 2'h3 : s.zeroRun + 2'h1);
      // A substitution clears the whole four-bit window, hiding its B pulse
      next_s.shiftData = sub ? 4'h0 : {s.shiftData[2:0], pulse};
      if (singleRail) begin
        next_s.rxPos = s.shiftData[3];
        next_s.rxNeg = bpv && !sub;
      end else begin
        next_s.rxPos = s.posSeen;
        next_s.rxNeg = s.negSeen;
      end
      if (pulse) begin
        next_s.losCnt = 12'h000;
      end else if (s.losCnt < losThr) begin
        next_s.losCnt = s.losCnt + 12'h001;
      end
      next_s.los = (next_s.losCnt >= losThr);
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from state; only the enable is a gate
  assign txLineTip = s.tip;
  assign txLineRing = s.ring;
  assign txLineOe = !s.sync2[`E1CT_PD] && floatN;
  assign recClk = s.rclk;
  assign rxPosNrz = s.rxPos;
  assign rxNegViol = s.rxNeg;
  assign signalLoss = s.los;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_pdHeld;
    txPowerdown [*3];
  endsequence
  property p_pd;
    s_pdHeld |-> !txLineOe ##1 (!txLineTip && !txLineRing);
  endproperty
  a_pd: assert property (p_pd) else $error("Line driven during power-down");
  property p_losSet;
    $rose(signalLoss) |-> $past(wrap) && (s.losCnt >= losThr);
  endproperty
  a_losSet: assert property (p_losSet) else $error("Loss raised early");
  property p_losClr;
    wrap && pulse |=> !signalLoss;
  endproperty
  a_losClr: assert property (p_losClr) else $error("Loss kept with a pulse");
  property p_dual;
    wrap && !singleRail |=> rxPosNrz == $past(s.posSeen) && rxNegViol == $past(s.negSeen);
  endproperty
  a_dual: assert property (p_dual) else $error("Dual-rail data wrong");
  property p_srData;
    wrap && singleRail |=> rxPosNrz == $past(s.shiftData[3]);
  endproperty
  a_srData: assert property (p_srData) else $error("NRZ data wrong");
  property p_viol;
    wrap && singleRail && bpv && !sub |=> rxNegViol ##1 (rxNegViol || $rose(recClk));
  endproperty
  a_viol: assert property (p_viol) else $error("Violation not flagged");
  property p_ami;
    wrap && singleRail && amiSel && bpv |=> rxNegViol;
  endproperty
  a_ami: assert property (p_ami) else $error("AMI violation missed");
  property p_aos;
    !s.sync2[`E1CT_PD] && s.sync2[`E1CT_AOS] && mclkRise |=> txLineTip != txLineRing;
  endproperty
  a_aos: assert property (p_aos) else $error("All-ones mark missing");
  property p_sync;
    ($changed(rxPosNrz) || $changed(rxNegViol)) |-> $rose(recClk);
  endproperty
  a_sync: assert property (p_sync) else $error("Data moved off rclk edge");

endmodule : e1ct_channel

// ===== e1ct_far_end.sv
module e1ct_far_end (
  // Bench choices for the transmit rails
  input wire logic txPos,
  input wire logic txNeg,
  // Terminal-side clocks and data
  output logic txClk,
  output logic txP,
  output logic txN,
  output logic mclk,
  // Sliced receive line pulses
  output logic lineTip,
  output logic lineRing
);
  timeunit 1ns;
  timeprecision 100ps;

  // Transmit clock runs free, as a framer's bit clock does
  initial begin
    txClk = 1'b0;
    forever #40 txClk = ~txClk;
  end

  // Master clock at the E1 rate, unrelated in phase to the others
  initial begin
    mclk = 1'b0;
    #7;
    forever #244 mclk = ~mclk;
  end

  // Data change on the falling edge so they stand still around the rise
  always @(negedge txClk) begin
    txP <= txPos;
    txN <= txNeg;
  end

  initial begin
    txP = 1'b0;
    txN = 1'b0;
    lineTip = 1'b0;
    lineRing = 1'b0;
  end

  // One line bit: return-to-zero mark in the first half, space after
  task automatic send(input logic p, input logic n);
    lineTip <= p;
    lineRing <= n;
    #244;
    lineTip <= 1'b0;
    lineRing <= 1'b0;
    #244;
  endtask : send
endmodule : e1ct_far_end

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, board_test_float_n, rxPinOe, pd2, aos, txPos, txNeg;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, ws;
  logic txClk, txP, txN, mclk, lineTip, lineRing;
  logic recovered_clock_ch2, rx_posrail_or_nrz_ch2, rx_negrail_or_violation_ch2, signal_loss_ch2;
  logic tx_line_tip_ch2, tx_line_ring_ch2, tx_line_oe_ch2, tx_line_oe_ch4;
  logic [15:0] histP, histN;
  int errors, compares;

  e1ct_far_end far (.txPos, .txNeg, .txClk, .txP, .txN, .mclk, .lineTip, .lineRing);

  e1ct_terminal dut (.ref_clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .master_clock(mclk), .board_test_float_n, .rxPinOe,
    .tx_clock_ch2(txClk), .tx_posrail_or_nrz_ch2(txP), .tx_negrail_or_coding_sel_ch2(txN),
    .tx_all_ones_ch2(aos), .tx_powerdown_ch2(pd2), .recovered_clock_ch2,
    .rx_posrail_or_nrz_ch2, .rx_negrail_or_violation_ch2, .signal_loss_ch2,
    .rx_line_tip_ch2(lineTip), .rx_line_ring_ch2(lineRing), .tx_line_tip_ch2,
    .tx_line_ring_ch2, .tx_line_oe_ch2, .tx_clock_ch4(txClk), .tx_posrail_or_nrz_ch4(txP),
    .tx_negrail_or_coding_sel_ch4(txN), .tx_all_ones_ch4(aos), .tx_powerdown_ch4(1'b0),
    .recovered_clock_ch4(), .rx_posrail_or_nrz_ch4(), .rx_negrail_or_violation_ch4(),
    .signal_loss_ch4(), .rx_line_tip_ch4(lineTip), .rx_line_ring_ch4(lineRing),
    .tx_line_tip_ch4(), .tx_line_ring_ch4(), .tx_line_oe_ch4);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Recovered bits, newest in bit 0; taken mid-bit, away from the rise that moves the data
  always @(negedge recovered_clock_ch2) begin
    histP <= {histP[14:0], rx_posrail_or_nrz_ch2};
    histN <= {histN[14:0], rx_negrail_or_violation_ch2};
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Pattern search: the recovery latency is not fixed, so any alignment counts
  function automatic logic [31:0] has(input logic [15:0] h, input logic [7:0] pat);
    for (int k = 0; k <= 8; k++) if (h[k+:8] === pat) return 32'h1;
    return 32'h0;
  endfunction : has

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    ws = bresp;
    bready <= 1'b0;
  endtask : axw

  task axr(input logic [3:0] a);
    @(posedge ref_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata; rs = rresp; rready <= 1'b0;
  endtask : axr

  // Eight bits oldest first, then eight spaces to flush the recovery delay
  task send_seq(input logic [7:0] p, input logic [7:0] n);
    for (int i = 7; i >= 0; i--) far.send(p[i], n[i]);
    repeat (8) far.send(1'b0, 1'b0);
  endtask : send_seq

  task t_regs;
    axr(4'h0); chk(rd, 32'h0);
    axr(4'h4); chk(rd, 32'h20);
    axr(4'hC); chk({rs, rd[29:0]}, {2'h2, 30'h0}); // Unmapped place
    axw(4'h4, 32'h0000_0ABC);
    chk({30'h0, ws}, 32'h0);
    axr(4'h4);
    chk(rd, 32'hABC);
    axw(4'hC, 32'h1);
    chk({30'h0, ws}, 32'h2); // Unmapped place
    axw(4'h4, 32'h20);
  endtask : t_regs

  task t_float;
    chk({rxPinOe, tx_line_oe_ch2, tx_line_oe_ch4}, 32'h7);
    pd2 <= 1'b1; cyc(10);
    chk({tx_line_oe_ch2, tx_line_oe_ch4}, 32'h1);
    pd2 <= 1'b0; board_test_float_n <= 1'b0; cyc(10);
    chk({rxPinOe, tx_line_oe_ch2, tx_line_oe_ch4}, 32'h0);
    board_test_float_n <= 1'b1; cyc(10);
  endtask : t_float

  task t_tx_dual;
    txPos <= 1'b1; txNeg <= 1'b0; cyc(40);
    chk({tx_line_tip_ch2, tx_line_ring_ch2}, 32'h2);
    txPos <= 1'b0; txNeg <= 1'b1; cyc(40);
    chk({tx_line_tip_ch2, tx_line_ring_ch2}, 32'h1);
    txNeg <= 1'b0;
  endtask : t_tx_dual

  // All-ones must alternate tip and ring, never both at once
  task t_all_ones;
    logic sT, sR, sB;
    sT = 0; sR = 0; sB = 0;
    aos <= 1'b1; cyc(20);
    repeat (400) begin
      @(posedge ref_clk);
      sT |= tx_line_tip_ch2; sR |= tx_line_ring_ch2; sB |= tx_line_tip_ch2 & tx_line_ring_ch2;
    end
    chk({sT, sR, sB}, 32'h6);
    aos <= 1'b0; cyc(40);
  endtask : t_all_ones

  task t_rx_dual;
    send_seq(8'hB0, 8'h48);
    chk(has(histP, 8'hB0), 32'h1);
    chk(has(histN, 8'h48), 32'h1);
  endtask : t_rx_dual

  task t_loss;
    axw(4'h4, 32'h4);
    send_seq(8'h00, 8'h00);
    chk({31'h0, signal_loss_ch2}, 32'h1);
    axr(4'h8); chk(rd, 32'h3);
    far.send(1'b1, 1'b0); far.send(1'b0, 1'b0);
    chk({31'h0, signal_loss_ch2}, 32'h0);
    axw(4'h4, 32'h20);
  endtask : t_loss

  // Minus, plus, space, plus: only the last mark breaks alternation
  task t_rx_single;
    axw(4'h0, 32'h1); txNeg <= 1'b1;
    repeat (8) far.send(1'b0, 1'b0);
    send_seq(8'h50, 8'h80);
    chk(has(histP, 8'hD0), 32'h1);
    chk($countones(histN), 32'h1);
    txNeg <= 1'b0;
  endtask : t_rx_single

  // Single-rail marks alternate tip and ring, never both at once
  task t_tx_single;
    logic sT, sR, sB;
    sT = 0;
    sR = 0;
    sB = 0;
    txPos <= 1'b1;
    cyc(20);
    repeat (200) begin
      @(posedge ref_clk);
      sT |= tx_line_tip_ch2;
      sR |= tx_line_ring_ch2;
      sB |= tx_line_tip_ch2 & tx_line_ring_ch2;
    end
    chk({sT, sR, sB}, 32'h6);
    txPos <= 1'b0;
  endtask : t_tx_single

  // HDB3: minus, B plus, two spaces, V plus; the substitution hides B and V
  task t_rx_hdb3;
    txNeg <= 1'b0;
    cyc(40);
    send_seq(8'h48, 8'h80);
    chk($countones(histP), 32'h1);
    chk($countones(histN), 32'h0);
  endtask : t_rx_hdb3

  task give_verdict;
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Watchdog: the tests need about 40 us
  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0; compares = 0; nrst = 1'b0; board_test_float_n = 1'b1; pd2 = 1'b0;
    aos = 1'b0; txPos = 1'b0; txNeg = 1'b0; awvalid = 1'b0; awaddr = 4'h0; wvalid = 1'b0;
    wdata = 32'h0; wstrb = 4'hF; bready = 1'b0; arvalid = 1'b0; araddr = 4'h0; rready = 1'b0;
    histP = 16'h0; histN = 16'h0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(5);
    t_regs();
    t_float();
    t_tx_dual();
    t_all_ones();
    t_rx_dual();
    t_loss();
    t_rx_single();
    t_tx_single();
    t_rx_hdb3();
    give_verdict();
  end
endmodule : testbench
